// [hdl/pcfr_pkg.sv]
package pcfr_pkg;

   // command codes of the configuration words
   localparam logic [7:0] PCFR_CMD_LOAD_LINE_SLOPE = 8'h28;
   localparam logic [7:0] PCFR_CMD_SENSE_LOOP_GAIN = 8'h29;
   localparam logic [7:0] PCFR_CMD_MONITOR_SCALE = 8'h2a;
   localparam logic [7:0] PCFR_CMD_DUTY_CEILING = 8'h32;
   localparam logic [7:0] PCFR_CMD_SWITCHING_FREQ = 8'h33;
   localparam logic [7:0] PCFR_CMD_TURN_ON = 8'h35;
   localparam logic [7:0] PCFR_CMD_TURN_OFF = 8'h36;
   localparam logic [7:0] PCFR_CMD_CURRENT_OFFSET = 8'h39;
   localparam logic [7:0] PCFR_CMD_OV_LIMIT = 8'h40;
   localparam logic [7:0] PCFR_CMD_OV_ACTION = 8'h41;

   // field positions of the over-voltage action byte
   localparam int PCFR_RESP_MSB = 7;
   localparam int PCFR_RESP_LSB = 6;
   localparam int PCFR_RETRY_MSB = 5;
   localparam int PCFR_RETRY_LSB = 3;
   localparam int PCFR_DELAY_MSB = 2;
   localparam int PCFR_DELAY_LSB = 0;

   // linear word: 5-bit signed exponent over 11-bit signed mantissa
   localparam int PCFR_EXP_MSB = 15;
   localparam int PCFR_EXP_LSB = 11;
   localparam int PCFR_MANT_MSB = 10;
   localparam int PCFR_FRAC = 8;

   // reset values
   localparam logic [15:0] PCFR_RST_WORD = 16'h0000;
   localparam logic [7:0] PCFR_RST_ACTION = 8'h00;

   localparam logic [1:0] PCFR_RESP_IGNORE = 2'b00;
   localparam logic [1:0] PCFR_RESP_DELAYED = 2'b01;
   localparam logic [1:0] PCFR_RESP_DISABLE_RETRY = 2'b10;
   localparam logic [1:0] PCFR_RESP_WHILE_PRESENT = 2'b11;
   localparam logic [2:0] PCFR_RETRY_NONE = 3'b000;
   localparam logic [2:0] PCFR_RETRY_ENDLESS = 3'b111;

   typedef enum logic [2:0] {
      PCFR_ST_RUN = 3'b000,
      PCFR_ST_DELAY = 3'b001,
      PCFR_ST_OFF_WAIT = 3'b010,
      PCFR_ST_RETRY = 3'b011,
      PCFR_ST_LATCHED = 3'b100,
      PCFR_ST_HOLD = 3'b101
   } pcfr_state_t;

   typedef struct packed {
      logic [PCFR_RESP_MSB-PCFR_RESP_LSB:0] response;
      logic [PCFR_RETRY_MSB-PCFR_RETRY_LSB:0] retries;
      logic [PCFR_DELAY_MSB-PCFR_DELAY_LSB:0] delay;
   } pcfr_action_t;

   typedef struct packed {
      logic [15:0] vin_lin;
      logic [15:0] vout_raw;
      logic [15:0] iout_lin;
   } pcfr_meas_t;

   // linear word to signed fixed point with PCFR_FRAC fraction bits
   function automatic logic signed [31:0] pcfr_lin_to_fix(input logic [15:0] w);
      logic signed [31:0] mant;
      logic signed [5:0] sh;
      mant = 32'(signed'(w[PCFR_MANT_MSB:0]));
      sh = 6'(signed'(w[PCFR_EXP_MSB:PCFR_EXP_LSB])) + 6'(PCFR_FRAC);
      if (sh[5] == 1'b0) begin
         pcfr_lin_to_fix = mant <<< sh[4:0];
      end else begin
         pcfr_lin_to_fix = mant >>> 5'(-sh);
      end
   endfunction : pcfr_lin_to_fix

endpackage : pcfr_pkg

// [hdl/pcfr_delay_timer.sv]
`timescale 1ns/100ps
module pcfr_delay_timer #(
   parameter int UNIT_W = 16
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_start,
   input wire logic i_stop,
   input wire logic [UNIT_W-1:0] i_unit_cycles,
   input wire logic [2:0] i_delay_code,
   output logic o_busy,
   output logic o_expired
);
   import pcfr_pkg::*;

   if (UNIT_W < 2 || UNIT_W > 24) begin : g_bad_width
      $error("pcfr_delay_timer: UNIT_W must lie in 2..24");
   end

   logic [UNIT_W-1:0] div;
   logic [UNIT_W-1:0] next_div;
   logic [7:0] units;
   logic [7:0] next_units;
   logic [7:0] target;
   logic [7:0] next_target;
   logic next_busy;
   logic next_expired;
   logic unit_tick;

   always_comb begin
      next_div = div;
      next_units = units;
      next_target = target;
      next_busy = o_busy;
      next_expired = 1'b0;
      // one-cycle enable at the end of each delay unit; a zero unit acts as one cycle
      unit_tick = o_busy && (UNIT_W'(div + 1'b1) >= i_unit_cycles);
      if (i_start) begin
         next_busy = 1'b1;
         next_div = '0;
         next_units = 8'h00;
         next_target = 8'h01 << i_delay_code;
      end else if (i_stop) begin
         next_busy = 1'b0;
      end else if (o_busy) begin
         if (unit_tick) begin
            next_div = '0;
            if (8'(units + 8'h01) == target) begin
               next_busy = 1'b0;
               next_expired = 1'b1;
            end else begin
               next_units = 8'(units + 8'h01);
            end
         end else begin
            next_div = UNIT_W'(div + 1'b1);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         div <= '0;
         units <= 8'h00;
         target <= 8'h01;
         o_busy <= 1'b0;
         o_expired <= 1'b0;
      end else begin
         div <= next_div;
         units <= next_units;
         target <= next_target;
         o_busy <= next_busy;
         o_expired <= next_expired;
      end
   end

endmodule : pcfr_delay_timer

// [hdl/pcfr_config_fault.sv]
`timescale 1ns/100ps
module pcfr_config_fault #(
   parameter int UNIT_W = 16,
   parameter logic [15:0] SWITCH_FREQ_WORD = 16'h0000
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_cmd_code,
   input wire logic [15:0] i_wr_data,
   input wire pcfr_pkg::pcfr_meas_t i_meas,
   input wire logic signed [31:0] i_duty_req,
   input wire logic i_ctrl_pin,
   input wire logic i_operation_on,
   input wire logic i_clear_faults,
   input wire logic i_clear_ov_status,
   input wire logic [UNIT_W-1:0] i_delay_unit_cycles,
   output logic [15:0] o_rd_data,
   output logic o_rd_valid,
   output logic o_cmd_err,
   output logic o_output_enable,
   output logic o_converting,
   output logic o_ov_status,
   output pcfr_pkg::pcfr_state_t o_fault_state,
   output logic signed [31:0] o_duty_limited,
   output logic signed [31:0] o_iout_report,
   output logic signed [31:0] o_droop_mv,
   output logic [15:0] o_loop_gain,
   output logic [15:0] o_monitor_scale
);
   import pcfr_pkg::*;

   // configuration words
   logic [15:0] load_line_slope;
   logic [15:0] duty_cycle_ceiling;
   logic [15:0] input_turn_on_threshold;
   logic [15:0] input_turn_off_threshold;
   logic [15:0] current_reading_offset;
   logic [15:0] overvoltage_fault_limit;
   logic [7:0] overvoltage_fault_action;
   logic [15:0] next_slope;
   logic [15:0] next_gain;
   logic [15:0] next_scale;
   logic [15:0] next_ceiling;
   logic [15:0] next_on_thr;
   logic [15:0] next_off_thr;
   logic [15:0] next_cur_off;
   logic [15:0] next_ov_limit;
   logic [7:0] next_action;
   logic [15:0] next_rd_data;
   logic next_rd_valid;
   logic next_cmd_err;

   // ---------------- register bank ----------------
   always_comb begin
      next_slope = load_line_slope;
      next_gain = o_loop_gain;
      next_scale = o_monitor_scale;
      next_ceiling = duty_cycle_ceiling;
      next_on_thr = input_turn_on_threshold;
      next_off_thr = input_turn_off_threshold;
      next_cur_off = current_reading_offset;
      next_ov_limit = overvoltage_fault_limit;
      next_action = overvoltage_fault_action;
      next_rd_data = o_rd_data;
      next_rd_valid = 1'b0;
      next_cmd_err = 1'b0;
      if (i_wr_en) begin
         case (i_cmd_code)
            PCFR_CMD_LOAD_LINE_SLOPE: next_slope = i_wr_data;
            PCFR_CMD_SENSE_LOOP_GAIN: next_gain = i_wr_data;
            PCFR_CMD_MONITOR_SCALE: next_scale = i_wr_data;
            PCFR_CMD_DUTY_CEILING: next_ceiling = i_wr_data;
            PCFR_CMD_SWITCHING_FREQ: next_cmd_err = 1'b0;
            PCFR_CMD_TURN_ON: next_on_thr = i_wr_data;
            PCFR_CMD_TURN_OFF: next_off_thr = i_wr_data;
            PCFR_CMD_CURRENT_OFFSET: next_cur_off = i_wr_data;
            PCFR_CMD_OV_LIMIT: next_ov_limit = i_wr_data;
            PCFR_CMD_OV_ACTION: next_action = i_wr_data[7:0];
            default: next_cmd_err = 1'b1;
         endcase
      end else if (i_rd_en) begin
         next_rd_valid = 1'b1;
         case (i_cmd_code)
            PCFR_CMD_LOAD_LINE_SLOPE: next_rd_data = load_line_slope;
            PCFR_CMD_SENSE_LOOP_GAIN: next_rd_data = o_loop_gain;
            PCFR_CMD_MONITOR_SCALE: next_rd_data = o_monitor_scale;
            PCFR_CMD_DUTY_CEILING: next_rd_data = duty_cycle_ceiling;
            PCFR_CMD_SWITCHING_FREQ: next_rd_data = SWITCH_FREQ_WORD;
            PCFR_CMD_TURN_ON: next_rd_data = input_turn_on_threshold;
            PCFR_CMD_TURN_OFF: next_rd_data = input_turn_off_threshold;
            PCFR_CMD_CURRENT_OFFSET: next_rd_data = current_reading_offset;
            PCFR_CMD_OV_LIMIT: next_rd_data = overvoltage_fault_limit;
            PCFR_CMD_OV_ACTION: next_rd_data = {8'h00, overvoltage_fault_action};
            default: begin
               next_rd_data = 16'h0000;
               next_cmd_err = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         load_line_slope <= PCFR_RST_WORD;
         o_loop_gain <= PCFR_RST_WORD;
         o_monitor_scale <= PCFR_RST_WORD;
         duty_cycle_ceiling <= PCFR_RST_WORD;
         input_turn_on_threshold <= PCFR_RST_WORD;
         input_turn_off_threshold <= PCFR_RST_WORD;
         current_reading_offset <= PCFR_RST_WORD;
         overvoltage_fault_limit <= PCFR_RST_WORD;
         overvoltage_fault_action <= PCFR_RST_ACTION;
         o_rd_data <= 16'h0000;
         o_rd_valid <= 1'b0;
         o_cmd_err <= 1'b0;
      end else begin
         load_line_slope <= next_slope;
         o_loop_gain <= next_gain;
         o_monitor_scale <= next_scale;
         duty_cycle_ceiling <= next_ceiling;
         input_turn_on_threshold <= next_on_thr;
         input_turn_off_threshold <= next_off_thr;
         current_reading_offset <= next_cur_off;
         overvoltage_fault_limit <= next_ov_limit;
         overvoltage_fault_action <= next_action;
         o_rd_data <= next_rd_data;
         o_rd_valid <= next_rd_valid;
         o_cmd_err <= next_cmd_err;
      end
   end

   // ---------------- measurement path ----------------
   logic signed [31:0] vin_fix;
   logic signed [31:0] iout_fix;
   logic signed [31:0] ceiling_fix;
   logic signed [63:0] droop_prod;
   logic next_converting;
   logic signed [31:0] next_duty;
   logic signed [31:0] next_iout;
   logic signed [31:0] next_droop;

   always_comb begin
      vin_fix = pcfr_lin_to_fix(i_meas.vin_lin);
      iout_fix = pcfr_lin_to_fix(i_meas.iout_lin);
      ceiling_fix = pcfr_lin_to_fix(duty_cycle_ceiling);
      if (o_converting) begin
         next_converting = vin_fix > pcfr_lin_to_fix(input_turn_off_threshold);
      end else begin
         next_converting = vin_fix >= pcfr_lin_to_fix(input_turn_on_threshold);
      end
      next_duty = (i_duty_req > ceiling_fix) ? ceiling_fix : i_duty_req;
      next_iout = 32'(iout_fix + pcfr_lin_to_fix(current_reading_offset));
      droop_prod = pcfr_lin_to_fix(load_line_slope) * iout_fix;
      next_droop = droop_prod[PCFR_FRAC+31:PCFR_FRAC];
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_converting <= 1'b0;
         o_duty_limited <= 32'sh0000_0000;
         o_iout_report <= 32'sh0000_0000;
         o_droop_mv <= 32'sh0000_0000;
      end else begin
         o_converting <= next_converting;
         o_duty_limited <= next_duty;
         o_iout_report <= next_iout;
         o_droop_mv <= next_droop;
      end
   end

   // ---------------- fault response ----------------
   pcfr_action_t act;
   logic ctrl_meta;
   logic ctrl_sync;
   logic on_prev;
   logic on_now;
   logic on_rise;
   logic ov;
   logic clear_evt;
   logic [2:0] attempts;
   logic [2:0] next_attempts;
   pcfr_state_t next_state;
   logic next_out_en;
   logic next_ov_status;
   logic tmr_start;
   logic tmr_stop;
   logic tmr_expired;

   always_comb begin
      act = pcfr_action_t'(overvoltage_fault_action);
      on_now = ctrl_sync & i_operation_on;
      on_rise = on_now & ~on_prev;
      ov = i_meas.vout_raw > overvoltage_fault_limit;
      clear_evt = i_clear_faults | i_clear_ov_status | on_rise;
      next_state = o_fault_state;
      next_attempts = attempts;
      tmr_start = 1'b0;
      tmr_stop = 1'b0;
      case (o_fault_state)
         PCFR_ST_RUN: begin
            if (ov) begin
               case (act.response)
                  PCFR_RESP_IGNORE: next_state = PCFR_ST_RUN;
                  PCFR_RESP_DELAYED: begin
                     next_state = PCFR_ST_DELAY;
                     tmr_start = 1'b1;
                  end
                  PCFR_RESP_DISABLE_RETRY: begin
                     tmr_start = act.retries != PCFR_RETRY_NONE;
                     next_state = tmr_start ? PCFR_ST_OFF_WAIT : PCFR_ST_LATCHED;
                  end
                  default: next_state = PCFR_ST_HOLD;
               endcase
            end
         end
         PCFR_ST_DELAY: begin
            if (tmr_expired) begin
               if (!ov) begin
                  next_state = PCFR_ST_RUN;
               end else if (act.retries == PCFR_RETRY_NONE) begin
                  next_state = PCFR_ST_LATCHED;
               end else begin
                  next_state = PCFR_ST_OFF_WAIT;
                  tmr_start = 1'b1;
               end
            end
         end
         PCFR_ST_OFF_WAIT: begin
            if (tmr_expired) begin
               next_state = PCFR_ST_RETRY;
               next_attempts = 3'(attempts + 3'd1);
               tmr_start = 1'b1;
            end
         end
         PCFR_ST_RETRY: begin
            if (ov) begin
               tmr_start = (act.retries == PCFR_RETRY_ENDLESS)
                  || (attempts < act.retries);
               next_state = tmr_start ? PCFR_ST_OFF_WAIT : PCFR_ST_LATCHED;
            end else if (tmr_expired) begin
               next_state = PCFR_ST_RUN;
               next_attempts = 3'd0;
            end
         end
         PCFR_ST_LATCHED: next_state = PCFR_ST_LATCHED;
         PCFR_ST_HOLD: begin
            if (!ov) begin
               next_state = PCFR_ST_RUN;
            end
         end
         default: next_state = PCFR_ST_RUN;
      endcase
      if (!on_now || clear_evt) begin
         next_state = PCFR_ST_RUN;
         next_attempts = 3'd0;
         tmr_start = 1'b0;
         tmr_stop = 1'b1;
      end
      next_out_en = on_now && next_converting && ((next_state == PCFR_ST_RUN)
         || (next_state == PCFR_ST_DELAY) || (next_state == PCFR_ST_RETRY));
      next_ov_status = ov | (o_ov_status & ~clear_evt);
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ctrl_meta <= 1'b0;
         ctrl_sync <= 1'b0;
         on_prev <= 1'b0;
         attempts <= 3'd0;
         o_fault_state <= PCFR_ST_RUN;
         o_output_enable <= 1'b0;
         o_ov_status <= 1'b0;
      end else begin
         ctrl_meta <= i_ctrl_pin;
         ctrl_sync <= ctrl_meta;
         on_prev <= on_now;
         attempts <= next_attempts;
         o_fault_state <= next_state;
         o_output_enable <= next_out_en;
         o_ov_status <= next_ov_status;
      end
   end

   pcfr_delay_timer #(
      .UNIT_W(UNIT_W)
   ) u_delay_timer (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_start(tmr_start),
      .i_stop(tmr_stop),
      .i_unit_cycles(i_delay_unit_cycles),
      .i_delay_code(act.delay),
      .o_busy(),
      .o_expired(tmr_expired)
   );

endmodule : pcfr_config_fault

// [verif/pcfr_config_fault_monitor.sv]
`timescale 1ns/100ps
module pcfr_config_fault_monitor #(
   parameter int UNIT_W = 16,
   parameter logic [15:0] SWITCH_FREQ_WORD = 16'h0000
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_cmd_code,
   input wire logic [15:0] i_wr_data,
   input wire pcfr_pkg::pcfr_meas_t i_meas,
   input wire logic [UNIT_W-1:0] i_delay_unit_cycles,
   input wire logic [15:0] o_rd_data,
   input wire logic o_rd_valid,
   input wire logic o_output_enable,
   input wire logic o_ov_status,
   input wire pcfr_pkg::pcfr_state_t o_fault_state
);
   import pcfr_pkg::*;
   logic [7:0] act_q;
   logic [7:0] next_act;
   logic [15:0] lim_q;
   logic [15:0] next_lim;
   logic ov_now;
   logic [1:0] resp;
   // shadow copies of the action byte and the limit
   always_comb begin
      next_act = act_q;
      next_lim = lim_q;
      if (i_wr_en && i_cmd_code == PCFR_CMD_OV_ACTION) next_act = i_wr_data[7:0];
      if (i_wr_en && i_cmd_code == PCFR_CMD_OV_LIMIT) next_lim = i_wr_data;
      if (!i_nrst) begin
         next_act = PCFR_RST_ACTION;
         next_lim = PCFR_RST_WORD;
      end
   end
   always_ff @(posedge i_clk) begin
      act_q <= next_act;
      lim_q <= next_lim;
   end
   assign ov_now = i_meas.vout_raw > lim_q;
   assign resp = act_q[PCFR_RESP_MSB:PCFR_RESP_LSB];

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_ov_run(logic [1:0] r);
      ov_now && o_fault_state == PCFR_ST_RUN && o_output_enable && resp == r;
   endsequence

   property p_rd_answer;
      (i_rd_en && !i_wr_en) |=> o_rd_valid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
   property p_freq_fixed;
      (i_rd_en && !i_wr_en && i_cmd_code == PCFR_CMD_SWITCHING_FREQ)
         |=> o_rd_data == SWITCH_FREQ_WORD;
   endproperty
   a_freq_fixed: assert property (p_freq_fixed) else $error("frequency word changed");
   property p_ignore;
      s_ov_run(PCFR_RESP_IGNORE) |=> o_fault_state == PCFR_ST_RUN && o_output_enable;
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignored fault disturbed output");
   property p_delayed;
      s_ov_run(PCFR_RESP_DELAYED) |=> o_output_enable && o_fault_state == PCFR_ST_DELAY;
   endproperty
   a_delayed: assert property (p_delayed) else $error("delayed response wrong");
   property p_disable;
      s_ov_run(PCFR_RESP_DISABLE_RETRY) |=> !o_output_enable [*2];
   endproperty
   a_disable: assert property (p_disable) else $error("output not disabled");
   property p_hold_off;
      s_ov_run(PCFR_RESP_WHILE_PRESENT) |=> !o_output_enable && o_fault_state == PCFR_ST_HOLD;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("hold not entered");
   property p_hold_back;
      (o_fault_state == PCFR_ST_HOLD && !ov_now) |=> o_output_enable;
   endproperty
   a_hold_back: assert property (p_hold_back) else $error("output not resumed");
   property p_latched_off;
      o_fault_state == PCFR_ST_LATCHED |-> !o_output_enable;
   endproperty
   a_latched_off: assert property (p_latched_off) else $error("latched but enabled");
   property p_ov_flag;
      (ov_now && o_fault_state == PCFR_ST_RUN) |=> o_ov_status;
   endproperty
   a_ov_flag: assert property (p_ov_flag) else $error("fault flag not set");
   property p_retry_gap;
      (o_fault_state == PCFR_ST_OFF_WAIT && $past(o_fault_state) != PCFR_ST_OFF_WAIT
         && act_q[2:0] == 3'h0 && i_delay_unit_cycles == UNIT_W'(1))
         |-> ##[1:4] o_fault_state != PCFR_ST_OFF_WAIT;
   endproperty
   a_retry_gap: assert property (p_retry_gap) else $error("off wait too long");
endmodule : pcfr_config_fault_monitor

bind pcfr_config_fault pcfr_config_fault_monitor #(
   .UNIT_W(UNIT_W),
   .SWITCH_FREQ_WORD(SWITCH_FREQ_WORD)
) i_pcfr_config_fault_monitor (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
   .i_cmd_code(i_cmd_code), .i_wr_data(i_wr_data), .i_meas(i_meas),
   .i_delay_unit_cycles(i_delay_unit_cycles), .o_rd_data(o_rd_data),
   .o_rd_valid(o_rd_valid), .o_output_enable(o_output_enable),
   .o_ov_status(o_ov_status), .o_fault_state(o_fault_state)
);

// [verif/pcfr_host_model.sv]
`timescale 1ns/100ps
module pcfr_host_model (
   input wire logic i_clk,
   input wire logic [15:0] i_rd_data,
   input wire logic i_rd_valid,
   input wire logic i_cmd_err,
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [7:0] o_cmd_code,
   output logic [15:0] o_wr_data
);
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_cmd_code = 8'h00;
      o_wr_data = 16'h0000;
   end
   // one-cycle strobe; released lines show the inverse of the last value
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge i_clk);
      o_wr_en <= 1'b1;
      o_cmd_code <= c;
      o_wr_data <= d;
      @(posedge i_clk);
      o_wr_en <= 1'b0;
      o_cmd_code <= ~c;
      o_wr_data <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v,
                     output logic e);
      @(posedge i_clk);
      o_rd_en <= 1'b1;
      o_cmd_code <= c;
      @(posedge i_clk);
      o_rd_en <= 1'b0;
      o_cmd_code <= ~c;
      @(negedge i_clk);
      d = i_rd_data;
      v = i_rd_valid;
      e = i_cmd_err;
   endtask : rd
endmodule : pcfr_host_model

// [verif/pcfr_config_fault_tb_top.sv]
`timescale 1ns/100ps
module pcfr_config_fault_tb_top;
   import pcfr_pkg::*;
   localparam logic [15:0] FREQ_WORD = 16'h0123; // arbitrary
   logic clk, nrst, wr_en, rd_en, ctrl_pin, op_on, clr_f, clr_ov, rvalid, cerr;
   logic out_en, conv, ov_st;
   logic [7:0] cmd;
   logic [15:0] wdata, unit, rdata, gain, mscale;
   pcfr_meas_t meas;
   logic signed [31:0] duty_req, duty_lim, iout_rep, droop;
   pcfr_state_t state;
   int err_total, n_checks, t;
   logic [7:0] codes [8] = '{8'h28, 8'h29, 8'h2a, 8'h32, 8'h35, 8'h36, 8'h39, 8'h40};
   logic [15:0] cfg [8] = '{16'h0003, 16'h0000, 16'h0000, 16'h0050, 16'h0024,
                            16'h0020, 16'h0002, 16'h0100};
   logic [15:0] vins [4] = '{16'h0022, 16'h0024, 16'h0021, 16'h0020};
   pcfr_config_fault #(.UNIT_W(16), .SWITCH_FREQ_WORD(FREQ_WORD)) i_pcfr_config_fault (
      .i_clk(clk), .i_nrst(nrst), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_cmd_code(cmd),
      .i_wr_data(wdata), .i_meas(meas), .i_duty_req(duty_req), .i_ctrl_pin(ctrl_pin),
      .i_operation_on(op_on), .i_clear_faults(clr_f), .i_clear_ov_status(clr_ov),
      .i_delay_unit_cycles(unit), .o_rd_data(rdata), .o_rd_valid(rvalid),
      .o_cmd_err(cerr), .o_output_enable(out_en), .o_converting(conv),
      .o_ov_status(ov_st), .o_fault_state(state), .o_duty_limited(duty_lim),
      .o_iout_report(iout_rep), .o_droop_mv(droop), .o_loop_gain(gain),
      .o_monitor_scale(mscale));
   pcfr_host_model i_pcfr_host_model (.i_clk(clk), .i_rd_data(rdata), .i_rd_valid(rvalid),
      .i_cmd_err(cerr), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_cmd_code(cmd),
      .o_wr_data(wdata));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   task automatic chk_rd(input logic [7:0] c, input logic [15:0] e, input logic e_err);
      logic [15:0] d;
      logic v, x;
      i_pcfr_host_model.rd(c, d, v, x);
      chk(32'(d), 32'(e), "read data");
      chk(32'(v), 32'h0000_0001, "read valid");
      chk(32'(x), 32'(e_err), "command error");
   endtask : chk_rd
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic drive_ov(input logic on);
      @(posedge clk);
      meas.vout_raw <= on ? 16'h0200 : 16'h0080;
   endtask : drive_ov
   task automatic wait_st(input pcfr_state_t s, input int lim, input bit need, output int n_try);
      pcfr_state_t prev;
      int n;
      n_try = 0;
      prev = state;
      n = 0;
      while (state !== s && n < lim) begin
         @(negedge clk);
         if (state === PCFR_ST_RETRY && prev !== PCFR_ST_RETRY) n_try++;
         prev = state;
         n++;
      end
      if (need && state !== s) begin
         err_total++;
         $display("wrong value at %0t: state wait ran out", $time);
         print_verdict();
      end
   endtask : wait_st
   task automatic do_clear(input int k);
      @(posedge clk);
      if (k == 0) clr_f <= 1'b1;
      else if (k == 1) clr_ov <= 1'b1;
      else if (k == 2) ctrl_pin <= 1'b0;
      else op_on <= 1'b0;
      @(posedge clk);
      clr_f <= 1'b0;
      clr_ov <= 1'b0;
      repeat (4) @(posedge clk);
      ctrl_pin <= 1'b1;
      op_on <= 1'b1;
      cyc(6);
   endtask : do_clear
   task automatic fault_setup(input logic [7:0] a);
      drive_ov(1'b0);
      do_clear(0);
      i_pcfr_host_model.wr(PCFR_CMD_OV_ACTION, {8'h00, a});
      cyc(2);
   endtask : fault_setup
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      print_verdict();
   end
   initial begin
      nrst = 1'b0;
      meas = '0;
      duty_req = 32'sh0000_6400;
      ctrl_pin = 1'b1;
      op_on = 1'b1;
      clr_f = 1'b0;
      clr_ov = 1'b0;
      unit = 16'h0001;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         i_pcfr_host_model.wr(codes[i], {codes[i], ~codes[i]});
         chk_rd(codes[i], {codes[i], ~codes[i]}, 1'b0);
      end
      chk(32'(gain), 32'h0000_29d6, "loop gain");
      chk(32'(mscale), 32'h0000_2ad5, "monitor scale");
      i_pcfr_host_model.wr(PCFR_CMD_OV_ACTION, 16'hffa5);
      chk_rd(PCFR_CMD_OV_ACTION, 16'h00a5, 1'b0);
      i_pcfr_host_model.wr(PCFR_CMD_SWITCHING_FREQ, 16'hbeef);
      chk_rd(PCFR_CMD_SWITCHING_FREQ, FREQ_WORD, 1'b0);
      chk_rd(8'h34, 16'h0000, 1'b1);
      for (int i = 0; i < 8; i++) i_pcfr_host_model.wr(codes[i], cfg[i]);
      @(posedge clk);
      meas <= '{16'h0022, 16'h0080, 16'h0005};
      cyc(3);
      chk(duty_lim, 32'h0000_5000, "duty ceiling");
      chk(iout_rep, 32'h0000_0700, "current offset");
      chk(droop, 32'h0000_0f00, "droop");
      @(posedge clk);
      duty_req <= 32'sh0000_3000;
      cyc(3);
      chk(duty_lim, 32'h0000_3000, "duty below ceiling");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         meas.vin_lin <= vins[i];
         cyc(3);
         chk(32'(conv), 32'(i == 1 || i == 2), "converting");
      end
      @(posedge clk);
      meas.vin_lin <= 16'h0028;
      fault_setup(8'h00);
      drive_ov(1'b1);
      cyc(5);
      chk({out_en, ov_st, 30'(state)}, {2'b11, 30'(PCFR_ST_RUN)}, "ignore");
      drive_ov(1'b0);
      do_clear(1);
      chk(32'(ov_st), 32'h0000_0000, "status cleared");
      fault_setup(8'h42);
      drive_ov(1'b1);
      unit <= 16'h0002;
      // four units of two cycles: still delaying after 9, latched within 2 more
      cyc(9);
      chk({out_en, 31'(state)}, {1'b1, 31'(PCFR_ST_DELAY)}, "still delaying");
      wait_st(PCFR_ST_LATCHED, 2, 1'b1, t);
      chk(t, 0, "no retry");
      @(posedge clk);
      unit <= 16'h0001;
      for (int k = 0; k < 4; k++) begin
         fault_setup(8'h80);
         drive_ov(1'b1);
         wait_st(PCFR_ST_LATCHED, 20, 1'b1, t);
         drive_ov(1'b0);
         cyc(3);
         chk(32'(state), 32'(PCFR_ST_LATCHED), "stays latched");
         do_clear(k);
         chk({out_en, 31'(state)}, {1'b1, 31'(PCFR_ST_RUN)}, "cleared");
      end
      for (int r = 1; r < 7; r++) begin
         fault_setup({2'b10, 3'(r), 3'b000});
         drive_ov(1'b1);
         wait_st(PCFR_ST_LATCHED, 200, 1'b1, t);
         chk(t, r, "retry count");
      end
      fault_setup(8'hb8);
      drive_ov(1'b1);
      wait_st(PCFR_ST_LATCHED, 150, 1'b0, t);
      chk({31'(state != PCFR_ST_LATCHED), 1'(t > 7)}, 32'h0000_0003, "endless");
      fault_setup(8'hc0);
      drive_ov(1'b1);
      cyc(3);
      chk({out_en, 31'(state)}, {1'b0, 31'(PCFR_ST_HOLD)}, "hold");
      drive_ov(1'b0);
      cyc(3);
      chk({out_en, 31'(state)}, {1'b1, 31'(PCFR_ST_RUN)}, "resumed");
      fault_setup(8'h80);
      drive_ov(1'b1);
      wait_st(PCFR_ST_LATCHED, 20, 1'b1, t);
      @(posedge clk);
      nrst <= 1'b0;
      meas.vout_raw <= 16'h0000;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      cyc(6);
      chk({out_en, 31'(state)}, {1'b1, 31'(PCFR_ST_RUN)}, "reset clears");
      chk_rd(PCFR_CMD_OV_LIMIT, PCFR_RST_WORD, 1'b0);
      print_verdict();
   end
endmodule : pcfr_config_fault_tb_top
